/* File: rtl/cds_pkg.sv */
//------------------------------------------------------------------------------
// Overview of operation
// - True compare condition discards the fetched word, runs a no-operation cycle.
// - Less compare checks file below accumulator unsigned; opcode 0110 000a.
// - Skip instructions take one cycle, two on skip, three over two-word.
// - Skipping a two-word instruction inserts two full four-quarter idle cycles.
// - Access bit zero selects the fixed access bank, bank select ignored.
// - Access bit one uses bank select register to pick the general bank.
// - Extended set, access zero, file at most 5Fh gives indexed literal offset.
// - Decrement-skip-if-zero subtracts one from the file register, opcode 0010 11da.
// - Destination bit zero writes accumulator; one writes back the file register.
// - Decrement-skip-if-zero discards the prefetched word when result is zero.
// - Decrement-skip-if-nonzero, opcode 0100 11da, discards when result nonzero.
//------------------------------------------------------------------------------
package cds_pkg;

  //----------------------------------------------------------------------------
  // Widths
  //----------------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int INSN_W = 16;
  localparam int BANK_W = 4;
  localparam int CNT_W  = 2;

  //----------------------------------------------------------------------------
  // Register byte offsets
  //----------------------------------------------------------------------------
  localparam logic [7:0] OFS_INSN   = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_BANK   = 8'h08;
  localparam logic [7:0] OFS_CFG    = 8'h0c;
  localparam logic [7:0] OFS_INDEX  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CYCLES = 8'h18;

  //----------------------------------------------------------------------------
  // Field positions and reset values
  //----------------------------------------------------------------------------
  localparam int CFG_EXT_EN  = 0;
  localparam int SB_BUSY     = 0;
  localparam int SB_SKIP     = 1;
  localparam int SB_ILLEGAL  = 2;
  localparam int SB_ZERO     = 3;
  localparam int BIT_A       = 8;
  localparam int BIT_D       = 9;
  localparam logic [DATA_W-1:0] RST_ACC   = 8'h00;
  localparam logic [BANK_W-1:0] RST_BANK  = 4'h0;
  localparam logic [INSN_W-1:0] RST_INSN  = 16'h0000;
  localparam logic [ADDR_W-1:0] RST_INDEX = 12'h000;
  localparam logic [CNT_W-1:0]  RST_CNT   = 2'h0;
  localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  //----------------------------------------------------------------------------
  // Addressing constants
  //----------------------------------------------------------------------------
  localparam logic [DATA_W-1:0] LIT_OFS_MAX = 8'h5f;
  localparam logic [BANK_W-1:0] ACC_LOW     = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HIGH    = 4'hf;

  //----------------------------------------------------------------------------
  // Opcodes: compares on bits 15:9, decrements on bits 15:10
  //----------------------------------------------------------------------------
  localparam logic [6:0] OPC_CMP_LT = 7'h30;
  localparam logic [6:0] OPC_CMP_EQ = 7'h31;
  localparam logic [6:0] OPC_CMP_GT = 7'h32;
  localparam logic [5:0] OPC_DEC_Z  = 6'h0b;
  localparam logic [5:0] OPC_DEC_NZ = 6'h13;

  //----------------------------------------------------------------------------
  // Quarter phases
  //----------------------------------------------------------------------------
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CDS_IDLE = 4'h1,
    CDS_EXEC = 4'h2,
    CDS_NOP1 = 4'h4,
    CDS_NOP2 = 4'h8
  } cds_state_e;

  typedef enum logic [2:0] {
    K_NONE   = 3'h0,
    K_CMP_LT = 3'h1,
    K_CMP_EQ = 3'h2,
    K_CMP_GT = 3'h3,
    K_DEC_Z  = 3'h4,
    K_DEC_NZ = 3'h5
  } cds_kind_e;

  // Opcode decode
  function automatic cds_kind_e cds_decode(input logic [INSN_W-1:0] insn);
    cds_kind_e k;
    k = K_NONE;
    if (insn[15:9] == OPC_CMP_LT) k = K_CMP_LT;
    if (insn[15:9] == OPC_CMP_EQ) k = K_CMP_EQ;
    if (insn[15:9] == OPC_CMP_GT) k = K_CMP_GT;
    if (insn[15:10] == OPC_DEC_Z) k = K_DEC_Z;
    if (insn[15:10] == OPC_DEC_NZ) k = K_DEC_NZ;
    return k;
  endfunction

endpackage

/* File: rtl/cds_addr.sv */
`timescale 1ns/100ps
// Operand address former, purely combinational
module cds_addr
  import cds_pkg::*;
(
  input  wire logic [DATA_W-1:0] file_i,
  input  wire logic              access_i,
  input  wire logic [BANK_W-1:0] bank_i,
  input  wire logic              ext_en_i,
  input  wire logic [ADDR_W-1:0] index_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   indexed_o
);

  logic [ADDR_W-1:0] sum;

  // Index plus literal offset, carry out of the map dropped
  assign sum = index_i + {{(ADDR_W-DATA_W){1'b0}}, file_i};

  // Pick among indexed, access and banked forms
  always_comb begin
    indexed_o = 1'b0;
    if (access_i) begin
      addr_o = {bank_i, file_i};
    end else if (ext_en_i && (file_i <= LIT_OFS_MAX)) begin
      addr_o    = sum;
      indexed_o = 1'b1;
    end else begin
      addr_o = (file_i <= LIT_OFS_MAX) ? {ACC_LOW, file_i} : {ACC_HIGH, file_i};
    end
  end

endmodule

/* File: rtl/cds_exec.sv */
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
// Compare and decrement skip execution unit
module cds_exec
  import cds_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              next_two_word_i,
  output logic                   discard_o,
  output logic                   nop_cycle_o,
  output logic                   busy_o,
  output logic                   done_o,
  output logic      [1:0]        quarter_o,
  output logic      [ADDR_W-1:0] dmem_addr_o,
  input  wire logic [DATA_W-1:0] dmem_rdata_i,
  output logic      [DATA_W-1:0] dmem_wdata_o,
  output logic                   dmem_we_o
);

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  cds_state_e        state;
  cds_state_e        next_state;
  cds_kind_e         kind;
  logic [1:0]        quarter;
  logic [INSN_W-1:0] insn;
  logic [DATA_W-1:0] acc;
  logic [BANK_W-1:0] bank;
  logic              ext_en;
  logic [ADDR_W-1:0] index;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] result;
  logic              skip;
  logic              two_word;
  logic              illegal;
  logic              zero;
  logic [CNT_W-1:0]  cycles;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W+0:0] diff;
  logic [DATA_W-1:0] dec_val;
  logic              cond;
  logic              is_dec;
  logic              wb_req;
  logic              wb_wr;
  logic              start;
  logic              at_q1;
  logic              at_q3;
  logic              at_q4;
  logic              last_q;
  logic [31:0]       rd_mux;

  //----------------------------------------------------------------------------
  // Bus request decode
  //----------------------------------------------------------------------------
  // Writes land on the edge where the master sees ack
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr  = wb_req && wb_we_i && wb_ack_o;
  // New instruction only accepted while idle; a busy write is dropped
  assign start  = wb_wr && (wb_adr_i == OFS_INSN) && wb_sel_i[0] && (state == CDS_IDLE);

  // Phase helpers
  assign at_q1 = (state == CDS_EXEC) && (quarter == Q1);
  assign at_q3 = (state == CDS_EXEC) && (quarter == Q3);
  assign at_q4 = (state == CDS_EXEC) && (quarter == Q4);
  assign is_dec = (kind == K_DEC_Z) || (kind == K_DEC_NZ);

  //----------------------------------------------------------------------------
  // Operand address
  //----------------------------------------------------------------------------
  cds_addr u_addr (
    .file_i    (insn[DATA_W-1:0]),
    .access_i  (insn[BIT_A]),
    .bank_i    (bank),
    .ext_en_i  (ext_en),
    .index_i   (index),
    .addr_o    (op_addr),
    .indexed_o ()
  );

  //----------------------------------------------------------------------------
  // Arithmetic
  //----------------------------------------------------------------------------
  // Nine-bit difference keeps the borrow for unsigned order
  // File minus accumulator
  assign diff    = {1'b0, rd_data} - {1'b0, acc};
  assign dec_val = rd_data - ONE_BYTE;

  // Skip condition per kind
  always_comb begin
    unique case (kind)
      K_CMP_GT: cond = !diff[DATA_W] && (diff[DATA_W-1:0] != ZERO_BYTE);
      K_CMP_LT: cond = diff[DATA_W];
      K_CMP_EQ: cond = (diff[DATA_W-1:0] == ZERO_BYTE);
      K_DEC_Z:  cond = (dec_val == ZERO_BYTE);
      K_DEC_NZ: cond = (dec_val != ZERO_BYTE);
      default:  cond = 1'b0;
    endcase
  end

  //----------------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------------
  // Last quarter of whichever cycle ends the instruction
  assign last_q = (quarter == Q4) &&
                  (((state == CDS_EXEC) && !skip) ||
                   ((state == CDS_NOP1) && !two_word) ||
                   (state == CDS_NOP2));

  // Next state at cycle boundaries
  always_comb begin
    next_state = state;
    unique case (state)
      CDS_IDLE: if (start) next_state = CDS_EXEC;
      CDS_EXEC: if (quarter == Q4) next_state = skip ? CDS_NOP1 : CDS_IDLE;
      // Two-word target needs a second idle cycle
      CDS_NOP1: if (quarter == Q4) next_state = two_word ? CDS_NOP2 : CDS_IDLE;
      CDS_NOP2: if (quarter == Q4) next_state = CDS_IDLE;
      default:  next_state = CDS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CDS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Quarter counter, wraps every four clocks while active
  always_ff @(posedge clk_i) begin
    if (rst_i || (state == CDS_IDLE)) begin
      quarter <= Q1;
    end else begin
      quarter <= quarter + 2'h1;
    end
  end

  // Instruction cycles used: one, two or three
  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      cycles <= RST_CNT;
    end else if ((state != CDS_IDLE) && (quarter == Q4)) begin
      cycles <= cycles + 2'h1;
    end
  end

  //----------------------------------------------------------------------------
  // Datapath by quarter
  //----------------------------------------------------------------------------
  // Decode in first quarter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind    <= K_NONE;
      illegal <= 1'b0;
    end else if (at_q1) begin
      kind    <= cds_decode(insn);
      illegal <= (cds_decode(insn) == K_NONE);
    end
  end

  // Operand address latched in first quarter, held to the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_addr_o <= RST_INDEX;
    end else if (at_q1) begin
      dmem_addr_o <= op_addr;
    end
  end

  // Read file register in second quarter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data <= ZERO_BYTE;
    end else if ((state == CDS_EXEC) && (quarter == Q2)) begin
      rd_data <= dmem_rdata_i;
    end
  end

  // Compute in third quarter; prefetch width sampled here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result   <= ZERO_BYTE;
      skip     <= 1'b0;
      two_word <= 1'b0;
      zero     <= 1'b0;
    end else if (at_q3) begin
      result   <= is_dec ? dec_val : diff[DATA_W-1:0];
      skip     <= cond;
      two_word <= cond && next_two_word_i;
      zero     <= is_dec ? (dec_val == ZERO_BYTE) : (diff[DATA_W-1:0] == ZERO_BYTE);
    end
  end

  // File write-back in Q4 only for decrement with d set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dmem_we_o    <= 1'b0;
      dmem_wdata_o <= ZERO_BYTE;
    end else begin
      dmem_we_o    <= at_q3 && is_dec && insn[BIT_D];
      dmem_wdata_o <= at_q3 ? dec_val : dmem_wdata_o;
    end
  end

  // Discard pulse during Q4 of a true condition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      discard_o <= 1'b0;
    end else begin
      discard_o <= at_q3 && cond;
    end
  end

  //----------------------------------------------------------------------------
  // Software registers
  //----------------------------------------------------------------------------
  // Instruction word; dropped while busy to keep the running one stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insn <= RST_INSN;
    end else if (start) begin
      insn[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) insn[15:8] <= wb_dat_i[15:8];
    end
  end

  // Accumulator: hardware result wins over a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= RST_ACC;
    end else if (at_q4 && is_dec && !insn[BIT_D]) begin
      acc <= result;
    end else if (wb_wr && (wb_adr_i == OFS_ACC) && wb_sel_i[0]) begin
      acc <= wb_dat_i[DATA_W-1:0];
    end
  end

  // Bank select and configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank   <= RST_BANK;
      ext_en <= 1'b0;
    end else if (wb_wr && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_BANK) bank <= wb_dat_i[BANK_W-1:0];
      if (wb_adr_i == OFS_CFG) ext_en <= wb_dat_i[CFG_EXT_EN];
    end
  end

  // Index base for literal offset mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index <= RST_INDEX;
    end else if (wb_wr && (wb_adr_i == OFS_INDEX)) begin
      if (wb_sel_i[0]) index[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) index[11:8] <= wb_dat_i[11:8];
    end
  end

  //----------------------------------------------------------------------------
  // Bus read and acknowledge
  //----------------------------------------------------------------------------
  // Read mux; unmapped offsets answer zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_INSN:   rd_mux[INSN_W-1:0] = insn;
      OFS_ACC:    rd_mux[DATA_W-1:0] = acc;
      OFS_BANK:   rd_mux[BANK_W-1:0] = bank;
      OFS_CFG:    rd_mux[CFG_EXT_EN] = ext_en;
      OFS_INDEX:  rd_mux[ADDR_W-1:0] = index;
      OFS_STATUS: begin
        rd_mux[SB_BUSY]    = busy_o;
        rd_mux[SB_SKIP]    = skip;
        rd_mux[SB_ILLEGAL] = illegal;
        rd_mux[SB_ZERO]    = zero;
      end
      OFS_CYCLES: rd_mux[CNT_W-1:0] = cycles;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  //----------------------------------------------------------------------------
  // Pipeline status outputs
  //----------------------------------------------------------------------------
  assign busy_o      = (state != CDS_IDLE);
  // Whole idle cycles, all four quarters
  assign nop_cycle_o = (state == CDS_NOP1) || (state == CDS_NOP2);
  assign done_o      = last_q;
  assign quarter_o   = quarter;

endmodule

/* File: bench/cds_exec_chk.sv */
`timescale 1ns/100ps
module cds_exec_chk
  import cds_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic              next_two_word_i,
  input wire logic              discard_o,
  input wire logic              nop_cycle_o,
  input wire logic              busy_o,
  input wire logic              done_o,
  input wire logic [1:0]        quarter_o,
  input wire logic [ADDR_W-1:0] dmem_addr_o,
  input wire logic [DATA_W-1:0] dmem_wdata_o,
  input wire logic              dmem_we_o
);
  //----------------------------------------------------------------------------
  // Shadow of the running instruction
  //----------------------------------------------------------------------------
  logic [INSN_W-1:0] insn_q;
  logic              start_wr;
  logic              is_cmp;
  logic              is_dz;
  logic              is_dnz;

  // Starts refused while busy must not disturb the shadow
  assign start_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == OFS_INSN;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insn_q <= RST_INSN;
    end else if (start_wr && !busy_o) begin
      insn_q <= wb_dat_i[INSN_W-1:0];
    end
  end

  // Instruction classes
  assign is_cmp = insn_q[15:9] inside {OPC_CMP_LT, OPC_CMP_EQ, OPC_CMP_GT};
  assign is_dz  = insn_q[15:10] == OPC_DEC_Z;
  assign is_dnz = insn_q[15:10] == OPC_DEC_NZ;

  //----------------------------------------------------------------------------
  // Properties
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_discard_late: assert property (discard_o |-> busy_o && quarter_o == Q4 && !nop_cycle_o)
    else $error("discard outside last quarter of execute");
  a_skip_nop: assert property (discard_o |=> nop_cycle_o [*4])
    else $error("skip without a full idle cycle");
  a_two_word: assert property (discard_o && $past(next_two_word_i) |=> nop_cycle_o [*8])
    else $error("two-word skip without two idle cycles");
  a_skip_end: assert property (discard_o && !$past(next_two_word_i) |-> ##4 done_o ##1 !busy_o)
    else $error("single skip not two cycles long");
  a_plain_end: assert property (busy_o && quarter_o == Q4 && !nop_cycle_o && !discard_o |-> done_o)
    else $error("unskipped instruction not one cycle");
  a_cmp_nowrite: assert property (busy_o && is_cmp |-> !dmem_we_o)
    else $error("compare wrote data memory");
  a_dec_dest: assert property (dmem_we_o |-> (is_dz || is_dnz) && insn_q[BIT_D] && quarter_o == Q4)
    else $error("memory write without file destination");
  a_dz_skip: assert property (busy_o && is_dz && insn_q[BIT_D] && quarter_o == Q4 && !nop_cycle_o
    |-> discard_o == (dmem_wdata_o == ZERO_BYTE))
    else $error("zero skip decision wrong");
  a_dnz_skip: assert property (busy_o && is_dnz && insn_q[BIT_D] && quarter_o == Q4 && !nop_cycle_o
    |-> discard_o == (dmem_wdata_o != ZERO_BYTE))
    else $error("nonzero skip decision wrong");
  a_addr_hold: assert property (busy_o && !nop_cycle_o && quarter_o == Q3 |-> $stable(dmem_addr_o))
    else $error("operand address moved after read");

  c_two_word: cover property (discard_o && $past(next_two_word_i));
  c_dec_write: cover property (dmem_we_o);
  c_plain_done: cover property (done_o && !nop_cycle_o);
endmodule

bind cds_exec cds_exec_chk u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .next_two_word_i, .discard_o, .nop_cycle_o, .busy_o, .done_o, .quarter_o, .dmem_addr_o,
  .dmem_wdata_o, .dmem_we_o
);

/* File: bench/cds_exec_tb.sv */
`timescale 1ns/100ps
module cds_exec_tb
  import cds_pkg::*;
;
  logic              clk_i           = 1'b0;
  logic              rst_i           = 1'b1;
  logic              wb_cyc_i        = 1'b0;
  logic              wb_stb_i        = 1'b0;
  logic              wb_we_i         = 1'b0;
  logic [7:0]        wb_adr_i        = 8'h00;
  logic [3:0]        wb_sel_i        = 4'hf;
  logic [31:0]       wb_dat_i        = 32'h0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              next_two_word_i = 1'b0;
  logic              discard_o;
  logic              nop_cycle_o;
  logic              busy_o;
  logic              done_o;
  logic [1:0]        quarter_o;
  logic [ADDR_W-1:0] dmem_addr_o;
  logic [DATA_W-1:0] dmem_rdata_i    = 8'h00;
  logic [DATA_W-1:0] dmem_wdata_o;
  logic              dmem_we_o;
  int                num_errors      = 0;
  int                tests_run       = 0;

  cds_exec uut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .next_two_word_i, .discard_o, .nop_cycle_o, .busy_o, .done_o, .quarter_o,
    .dmem_addr_o, .dmem_rdata_i, .dmem_wdata_o, .dmem_we_o
  );

  // 20 MHz quarter clock
  always #25 clk_i = ~clk_i;

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    // A missing answer is a mismatch, not a silent pass
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("[FAIL] t=%0t ack %h exp %h", $time, wb_ack_o, 1'b1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    xfer(1'b1, adr, wd, rd);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, adr, 32'h0, rd);
    check(rd, exp);
  endtask

  // Starts one instruction and follows it quarter by quarter
  task automatic run(input logic [15:0] insn, input logic [7:0] acc, input logic [7:0] fv,
                     input logic two, input logic ext, input logic [3:0] bnk, input logic [11:0] idx);
    logic [7:0]  f;
    logic [7:0]  res;
    logic [7:0]  wd;
    logic [11:0] ea;
    logic [11:0] seen;
    logic        dec;
    logic        skip;
    logic        z;
    int          ncy;
    int          cyc;
    int          nops;
    int          disc;
    int          we;
    f    = insn[7:0];
    res  = fv - 8'h01;
    dec  = insn[15:10] == OPC_DEC_Z || insn[15:10] == OPC_DEC_NZ;
    if (dec) skip = (insn[15:10] == OPC_DEC_Z) ? res == 8'h00 : res != 8'h00;
    else if (insn[15:9] == OPC_CMP_LT) skip = fv < acc;
    else if (insn[15:9] == OPC_CMP_GT) skip = fv > acc;
    else skip = fv == acc;
    z    = dec ? res == 8'h00 : fv == acc;
    if (insn[BIT_A]) ea = {bnk, f};
    else if (ext && f <= 8'h5f) ea = idx + {4'h0, f};
    else ea = {(f <= 8'h5f) ? 4'h0 : 4'hf, f};
    ncy  = skip ? (two ? 3 : 2) : 1;
    cyc  = 0;
    nops = 0;
    disc = 0;
    we   = 0;
    seen = 12'h0;
    wd   = 8'h0;
    wr(OFS_ACC, {24'h0, acc});
    wr(OFS_BANK, {28'h0, bnk});
    wr(OFS_CFG, {31'h0, ext});
    wr(OFS_INDEX, {20'h0, idx});
    dmem_rdata_i    <= fv;
    next_two_word_i <= two;
    wr(OFS_INSN, {16'h0, insn});
    // Outputs are looked at mid-cycle, after the edge has settled
    for (int n = 0; n < 16; n++) begin
      @(negedge clk_i);
      if (busy_o === 1'b1) begin
        check(32'(quarter_o), 32'(cyc % 4));
        if (cyc == 1) seen = dmem_addr_o;
        if (nop_cycle_o === 1'b1) nops++;
        if (discard_o === 1'b1) disc++;
        if (dmem_we_o === 1'b1) we++;
        if (dmem_we_o === 1'b1) wd = dmem_wdata_o;
        cyc++;
        if (done_o === 1'b1) n = 16;
      end
    end
    check(32'(cyc), 32'(4 * ncy));
    check(32'(nops), 32'(4 * ncy - 4));
    check(32'(disc), {31'h0, skip});
    check({20'h0, seen}, {20'h0, ea});
    check(32'(we), {31'h0, dec && insn[BIT_D]});
    if (we > 0) check({24'h0, wd}, {24'h0, res});
    rd_chk(OFS_ACC, {24'h0, (dec && !insn[BIT_D]) ? res : acc});
    rd_chk(OFS_CYCLES, 32'(ncy));
    rd_chk(OFS_STATUS, {28'h0, z, 1'b0, skip, 1'b0});
    $display("Test %h done", insn);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  //----------------------------------------------------------------------------
  // Sequence
  //----------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_ACC, 32'h0);
    rd_chk(OFS_CYCLES, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    wr(8'h20, 32'hff);
    rd_chk(8'h20, 32'h0);
    run(16'h6580, 8'h7f, 8'h80, 1'b0, 1'b0, 4'h3, 12'h000);
    run(16'h6510, 8'h7f, 8'h7f, 1'b1, 1'b0, 4'h3, 12'h000);
    run(16'h6000, 8'h01, 8'h00, 1'b1, 1'b0, 4'h0, 12'h000);
    run(16'h6190, 8'h42, 8'h42, 1'b0, 1'b0, 4'h5, 12'h000);
    run(16'h6344, 8'h33, 8'h33, 1'b0, 1'b0, 4'h9, 12'h000);
    run(16'h2f22, 8'h00, 8'h01, 1'b0, 1'b0, 4'h2, 12'h000);
    run(16'h2dff, 8'h10, 8'h00, 1'b1, 1'b0, 4'hf, 12'h000);
    run(16'h4e60, 8'h00, 8'h05, 1'b1, 1'b0, 4'h0, 12'h000);
    run(16'h4d01, 8'h55, 8'h01, 1'b0, 1'b0, 4'h7, 12'h000);
    run(16'h645f, 8'h10, 8'h20, 1'b0, 1'b1, 4'h0, 12'hff0);
    run(16'h6460, 8'h10, 8'h20, 1'b0, 1'b1, 4'h0, 12'hff0);
    run(16'h655f, 8'h10, 8'h20, 1'b0, 1'b1, 4'ha, 12'hff0);
    // Unknown opcode: one cycle, no skip, flagged in status
    wr(OFS_INSN, 32'h0000_ffff);
    repeat (4) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h4);
    rd_chk(OFS_CYCLES, 32'h1);
    $display("Test illegal done");
    wrap_up;
  end

  // The sequence needs well under a thousand cycles; this is ample margin
  initial begin
    #200000;
    num_errors++;
    wrap_up;
  end
endmodule
